// file: dv/ssr_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// remote controller: issues commands and serial polls, polls for completion
module ssr_ctl_model
    import ssr_pkg::*;
(
    input  wire logic     i_mclk,
    input  wire ssr_rsp_t i_rsp,
    output ssr_cmd_t      o_cmd,
    output logic          o_poll,
    output logic          o_quiet
);
    // idle at time zero
    initial begin
        o_cmd   = '0;
        o_poll  = 1'b0;
        o_quiet = 1'b0;
    end

    // one command pulse; idle data inverted so a stale word never looks current
    task automatic access(input logic w, input logic r, input ssr_sel_t s,
                          input logic [15:0] d);
        @(posedge i_mclk);
        o_cmd <= '{wr: w, rd: r, sel: s, wdata: d};
        @(posedge i_mclk);
        o_cmd <= '{wr: 1'b0, rd: 1'b0, sel: s, wdata: ~d};
    endtask : access

    // serial poll pulse
    task automatic spoll;
        @(posedge i_mclk);
        o_poll <= 1'b1;
        @(posedge i_mclk);
        o_poll <= 1'b0;
    endtask : spoll

    // event latch read repeatedly, up to 32 times, until its completion bit shows
    task automatic poll_done(output int n);
        logic done;
        done = 1'b0;
        n = 0;
        // let the answer of a read issued just before still reach the watcher
        @(posedge i_mclk);
        o_quiet <= 1'b1;
        while (!done && n < 32) begin
            access(1'b0, 1'b1, SEL_ESL, 16'h0000);
            @(posedge i_mclk);
            done = i_rsp.valid & i_rsp.data[ESL_OPC];
            n++;
        end
        @(posedge i_mclk);
        o_quiet <= 1'b0;
    endtask : poll_done
endmodule : ssr_ctl_model

`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the status reporting tree
module tb;
    import ssr_pkg::*;
    logic        mclk;
    logic        rst_b;
    ssr_cmd_t    cmd;
    logic        poll;
    logic        quiet;
    logic [15:0] oper_cond;
    logic [15:0] ques_cond;
    logic [7:0]  esl_set;
    logic        errq;
    logic        msg;
    ssr_rsp_t    rsp;
    logic [7:0]  stb;
    logic        srq;
    logic        individual_status_flag;
    int          n_mismatch = 0;
    int          checks = 0;
    logic [15:0] exp_q[$];
    logic [31:0] seed;

    ssr_status_reporting i_ssr_status_reporting (.i_mclk(mclk), .i_rst_b(rst_b),
        .i_cmd(cmd), .i_serial_poll(poll), .i_oper_cond(oper_cond),
        .i_ques_cond(ques_cond), .i_esl_set(esl_set), .i_errq_nonempty(errq),
        .i_msg_waiting(msg), .o_rsp(rsp), .o_stb(stb), .o_srq(srq), .o_ist(individual_status_flag));
    ssr_ctl_model i_ssr_ctl_model (.i_mclk(mclk), .i_rsp(rsp), .o_cmd(cmd),
        .o_poll(poll), .o_quiet(quiet));

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // random source
    task automatic rnd(output logic [15:0] v);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        v = seed[15:0];
    endtask : rnd

    // comparison core and its two kinds of result
    task automatic judge(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : judge
    task automatic cmp_rsp(input logic [15:0] got, input logic [15:0] exp);
        judge(got, exp);
    endtask : cmp_rsp
    task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
        judge({8'h00, got}, {8'h00, exp});
    endtask : cmp_pin

    // bus helpers; reads and polls note their answer first
    task automatic wr(input ssr_sel_t s, input logic [15:0] d);
        i_ssr_ctl_model.access(1'b1, 1'b0, s, d);
    endtask : wr
    task automatic rd(input ssr_sel_t s, input logic [15:0] e);
        exp_q.push_back(e);
        i_ssr_ctl_model.access(1'b0, 1'b1, s, 16'h0000);
    endtask : rd
    task automatic sp(input logic [7:0] e);
        exp_q.push_back({8'h00, e});
        i_ssr_ctl_model.spoll();
    endtask : sp
    task automatic settle;
        repeat (4) @(posedge mclk);
    endtask : settle
    task automatic pulse_esl(input logic [7:0] v);
        @(posedge mclk);
        esl_set <= v;
        @(posedge mclk);
        esl_set <= 8'h00;
    endtask : pulse_esl

    // verdict
    task automatic tally_and_finish;
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // answer watcher: oldest note against each answer, unexpected ones fail
    always @(posedge mclk) begin
        if (rsp.valid === 1'b1 && !quiet) begin
            cmp_rsp(rsp.data, (exp_q.size() > 0) ? exp_q.pop_front() : ~rsp.data);
        end
    end

    // watchdog
    initial begin
        repeat (6000) @(posedge mclk);
        n_mismatch++;
        tally_and_finish();
    end

    // main sequence
    initial begin : main
        ssr_sel_t    ro_sel [7] = '{SEL_STB, SEL_ESL, SEL_IST, SEL_O_CND, SEL_O_EVT,
                                    SEL_Q_EVT, ssr_sel_t'(5'h1F)};
        ssr_sel_t    rw_sel [9] = '{SEL_SRE, SEL_ESM, SEL_PPM, SEL_O_RIS, SEL_O_FAL,
                                    SEL_O_ENA, SEL_Q_RIS, SEL_Q_FAL, SEL_Q_ENA};
        logic [15:0] rw_msk [9] = '{16'h00BF, 16'h00FF, 16'h00FF, 16'h7FFF, 16'h7FFF,
                                    16'h7FFF, 16'h7FFF, 16'h7FFF, 16'h7FFF};
        logic [15:0] a, b, ris, fal, ena, ev, v;
        int          n;
        seed = 32'h6EF7F081;
        rst_b = 1'b0;
        oper_cond = 16'h0000;
        ques_cond = 16'h0000;
        esl_set = 8'h00;
        errq = 1'b0;
        msg = 1'b0;
        repeat (10) @(posedge mclk);
        cmp_pin({stb[7:2], srq, individual_status_flag}, 8'h00);
        rst_b <= 1'b1;
        // read-only places ignore writes; all read zero from reset
        foreach (ro_sel[i]) wr(ro_sel[i], 16'hFFFF);
        foreach (ro_sel[i]) rd(ro_sel[i], 16'h0000);
        foreach (rw_sel[i]) begin
            rd(rw_sel[i], 16'h0000);
            rnd(v);
            wr(rw_sel[i], v);
            rd(rw_sel[i], v & rw_msk[i]);
            rd(rw_sel[i], v & rw_msk[i]);
        end
        wr(SEL_SRE, 16'h0000);
        // transition filters, event latch and summaries of both registers
        for (int k = 0; k < 2; k++) begin
            ssr_sel_t base;
            base = k ? SEL_Q_CND : SEL_O_CND;
            rnd(ris); rnd(fal); rnd(ena); rnd(a); rnd(b);
            ris[0] = 1'b1;
            a[0] = 1'b1;
            ena[0] = 1'b1;
            wr(ssr_sel_t'(base + 5'h01), ris);
            wr(ssr_sel_t'(base + 5'h02), fal);
            wr(ssr_sel_t'(base + 5'h04), ena);
            @(posedge mclk);
            if (k) ques_cond <= a; else oper_cond <= a;
            settle();
            @(posedge mclk);
            if (k) ques_cond <= b; else oper_cond <= b;
            settle();
            ev = ((a & ris) | (~a & b & ris) | (a & ~b & fal)) & WORD_VALID;
            cmp_pin({7'h00, stb[k ? STB_QUES : STB_OPER]}, 8'h01);
            wr(base, 16'hFFFF);
            rd(base, b & WORD_VALID);
            rd(ssr_sel_t'(base + 5'h03), ev);
            rd(ssr_sel_t'(base + 5'h03), 16'h0000);
            settle();
            cmp_pin({7'h00, stb[k ? STB_QUES : STB_OPER]}, 8'h00);
        end
        // event status latch and its summary
        wr(SEL_ESM, 16'h0001);
        pulse_esl(8'hFF);
        settle();
        cmp_pin(stb, 8'h20);
        rd(SEL_ESL, {8'h00, ESL_USED});
        settle();
        cmp_pin(stb, 8'h00);
        // event arriving with the clearing read stays latched
        fork
            rd(SEL_ESL, 16'h0000);
            pulse_esl(8'h04);
        join
        rd(SEL_ESL, 16'h0004);
        // completion polling by the controller
        fork
            begin
                repeat (9) @(posedge mclk);
                pulse_esl(8'h01);
            end
            i_ssr_ctl_model.poll_done(n);
        join
        cmp_pin({7'h00, n > 1 && n < 32}, 8'h01);
        // error queue, message waiting, request and individual flag
        wr(SEL_SRE, 16'h0010);
        wr(SEL_PPM, 16'h0040);
        @(posedge mclk);
        errq <= 1'b1;
        settle();
        cmp_pin({stb[7:2], srq, individual_status_flag}, 8'h04);
        @(posedge mclk);
        msg <= 1'b1;
        settle();
        cmp_pin(stb, 8'h54);
        cmp_pin({6'h00, srq, individual_status_flag}, 8'h03);
        rd(SEL_STB, 16'h0054);
        rd(SEL_IST, 16'h0001);
        sp(8'h54);
        settle();
        cmp_pin({6'h00, srq, individual_status_flag}, 8'h01);
        @(posedge mclk);
        msg <= 1'b0;
        errq <= 1'b0;
        settle();
        cmp_pin({stb[7:2], srq, individual_status_flag}, 8'h00);
        cmp_pin(8'(exp_q.size()), 8'h00);
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire

// file: hdl/ssr_pkg.sv
package ssr_pkg;
    // status part geometry
    localparam int STAT_W   = 16;
    localparam int STAT_MSB = 15;
    localparam int BYTE_W   = 8;
    // status byte bit positions
    localparam int STB_ERRQ = 2;
    localparam int STB_QUES = 3;
    localparam int STB_MAV  = 4;
    localparam int STB_ESB  = 5;
    localparam int STB_MSS  = 6;
    localparam int STB_OPER = 7;
    // event status latch bit positions
    localparam int ESL_OPC  = 0;
    localparam int ESL_UNU  = 1;
    localparam int ESL_QYE  = 2;
    localparam int ESL_DDE  = 3;
    localparam int ESL_EXE  = 4;
    localparam int ESL_CME  = 5;
    localparam int ESL_URQ  = 6;
    localparam int ESL_PON  = 7;
    // masks and reset values
    localparam logic [7:0]  ESL_USED   = 8'hFD;
    localparam logic [7:0]  NOT_MSS    = 8'hBF;
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam logic [15:0] WORD_VALID = 16'h7FFF;
    // register selects on the command port
    typedef enum logic [4:0] {
        SEL_STB   = 5'h00,
        SEL_SRE   = 5'h01,
        SEL_ESL   = 5'h02,
        SEL_ESM   = 5'h03,
        SEL_PPM   = 5'h04,
        SEL_IST   = 5'h05,
        SEL_O_CND = 5'h08,
        SEL_O_RIS = 5'h09,
        SEL_O_FAL = 5'h0A,
        SEL_O_EVT = 5'h0B,
        SEL_O_ENA = 5'h0C,
        SEL_Q_CND = 5'h10,
        SEL_Q_RIS = 5'h11,
        SEL_Q_FAL = 5'h12,
        SEL_Q_EVT = 5'h13,
        SEL_Q_ENA = 5'h14
    } ssr_sel_t;
    // command from the message parser
    typedef struct packed {
        logic        wr;
        logic        rd;
        ssr_sel_t    sel;
        logic [15:0] wdata;
    } ssr_cmd_t;
    // read answer
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } ssr_rsp_t;
endpackage : ssr_pkg

// file: hdl/ssr_status_reporting.sv
// Functional notes
// - each status register has five 16-bit parts sharing one bit per source
// - bit 15 of every status part always reads zero
// - condition part follows hardware, ignores writes, unchanged by reads
// - condition rise sets event bit only when rising filter bit is one
// - condition fall sets event bit only when falling filter bit is one
// - both transition filters are read-write; reads leave them intact
// - event bits latch filtered transitions, device-set only, cleared on read
// - summary is OR over positions of event AND enable
// - enable part is read-write; reads leave it unchanged
// - each summary feeds a condition bit of the next higher register
// - status byte gathers event, operation and questionable summaries
// - status byte readable by query command or by serial poll
// - status byte bit 6 is summary of other bits under request mask
// - request mask has a bit per status bit; its bit 6 is ignored
// - service request raised when a masked status bit rises
// - status bit 2 shows error queue holds an entry
// - status bit 3 is questionable register summary
// - status bit 4 shows a readable response waits in output buffer
// - status bit 5 set when a latched event bit meets its mask bit
// - status bit 6 shows a masked status bit is set; it stays set after a serial poll clears the request
// - status bit 7 is operation register summary
// - parallel poll mask selects status bits feeding individual flag
// - individual flag is OR of status AND poll mask, bit 6 counted
// - event latch bit rising under its mask sets event summary bit
// - latch bits: completion, unused, query, device, execution, command, user, power
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// generic five-part status register
module ssr_status_reg
    import ssr_pkg::*;
#(
    parameter int W = STAT_W
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst_b,
    input  wire logic [W-1:0] i_cond,
    input  wire logic         i_wr_ris,
    input  wire logic         i_wr_fal,
    input  wire logic         i_wr_ena,
    input  wire logic [W-1:0] i_wdata,
    input  wire logic         i_rd_evt,
    output logic      [W-1:0] o_cond,
    output logic      [W-1:0] o_ris,
    output logic      [W-1:0] o_fal,
    output logic      [W-1:0] o_evt,
    output logic      [W-1:0] o_ena,
    output logic              o_sum
);
    // refuse widths the fixed field map cannot serve
    if (W != STAT_W) begin : g_width_chk
        $error("status part width must be 16");
    end

    logic [W-1:0] cond_ff, ris_ff, fal_ff, evt_ff, ena_ff;
    logic [W-1:0] cond_m, rise, fall, set_bits;
    logic [W-1:0] nxt_evt, nxt_ena, wdata_m;
    logic         sum_ff;

    // top bit forced low on every part
    assign cond_m  = i_cond & WORD_VALID;
    assign wdata_m = i_wdata & WORD_VALID;
    // transition filters
    assign rise     = cond_m & ~cond_ff;
    assign fall     = ~cond_m & cond_ff;
    assign set_bits = (rise & ris_ff) | (fall & fal_ff);
    // read clears, but same-cycle events survive
    assign nxt_evt = (i_rd_evt ? RST_WORD : evt_ff) | set_bits;
    assign nxt_ena = i_wr_ena ? wdata_m : ena_ff;

    // condition tracks hardware, no write path
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) cond_ff <= RST_WORD;
        else          cond_ff <= cond_m;
    end

    // transition filter parts
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ris_ff <= RST_WORD;
            fal_ff <= RST_WORD;
        end else begin
            if (i_wr_ris) ris_ff <= wdata_m;
            if (i_wr_fal) fal_ff <= wdata_m;
        end
    end

    // event, enable and summary
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            evt_ff <= RST_WORD;
            ena_ff <= RST_WORD;
            sum_ff <= 1'b0;
        end else begin
            evt_ff <= nxt_evt;
            ena_ff <= nxt_ena;
            sum_ff <= |(nxt_evt & nxt_ena);
        end
    end

    assign o_cond = cond_ff;
    assign o_ris  = ris_ff;
    assign o_fal  = fal_ff;
    assign o_evt  = evt_ff;
    assign o_ena  = ena_ff;
    assign o_sum  = sum_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_rise_latch;
        @(posedge i_mclk) disable iff (!i_rst_b)
        |(rise & ris_ff) |=> ((evt_ff & $past(rise & ris_ff)) == $past(rise & ris_ff));
    endproperty
    a_rise_latch: assert property (p_rise_latch) else $error("rise lost");

    property p_fall_latch;
        @(posedge i_mclk) disable iff (!i_rst_b)
        |(fall & fal_ff) |=> ((evt_ff & $past(fall & fal_ff)) == $past(fall & fal_ff));
    endproperty
    a_fall_latch: assert property (p_fall_latch) else $error("fall lost");

    property p_no_unfiltered;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!i_rd_evt && set_bits == RST_WORD) |=> $stable(evt_ff);
    endproperty
    a_no_unfiltered: assert property (p_no_unfiltered) else $error("event set");

    property p_read_clear;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_rd_evt && set_bits == RST_WORD) |=> (evt_ff == RST_WORD);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("no clear");

    property p_read_keep;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_rd_evt && set_bits != RST_WORD) |=> ((evt_ff & $past(set_bits)) != RST_WORD);
    endproperty
    a_read_keep: assert property (p_read_keep) else $error("event lost");

    property p_summary;
        @(posedge i_mclk) disable iff (!i_rst_b)
        sum_ff == |(evt_ff & ena_ff);
    endproperty
    a_summary: assert property (p_summary) else $error("bad summary");

    property p_filter_hold;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!i_wr_ris && !i_wr_fal && !i_wr_ena) |=> ($stable(ris_ff) && $stable(fal_ff) && $stable(ena_ff));
    endproperty
    a_filter_hold: assert property (p_filter_hold) else $error("mask moved");

    property p_msb_zero;
        @(posedge i_mclk) disable iff (!i_rst_b)
        !(cond_ff[STAT_MSB] | evt_ff[STAT_MSB] | ena_ff[STAT_MSB] | ris_ff[STAT_MSB] | fal_ff[STAT_MSB]);
    endproperty
    a_msb_zero: assert property (p_msb_zero) else $error("bit 15 set");

    property p_cond_track;
        @(posedge i_mclk) disable iff (!i_rst_b)
        ##1 cond_ff == $past(cond_m);
    endproperty
    a_cond_track: assert property (p_cond_track) else $error("cond stale");

endmodule : ssr_status_reg

////////////////////////////////////////////////////////////////////////////////
// status byte, event latch, request and poll logic
module ssr_status_reporting
    import ssr_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    input  wire ssr_cmd_t    i_cmd,
    input  wire logic        i_serial_poll,
    input  wire logic [15:0] i_oper_cond,
    input  wire logic [15:0] i_ques_cond,
    input  wire logic [7:0]  i_esl_set,
    input  wire logic        i_errq_nonempty,
    input  wire logic        i_msg_waiting,
    output ssr_rsp_t         o_rsp,
    output logic [7:0]       o_stb,
    output logic             o_srq,
    output logic             o_ist
);
    logic [7:0]  esl_ff, esm_ff, sre_ff, ppm_ff, stb_ff;
    logic [7:0]  nxt_esl, nxt_esm, nxt_sre, nxt_ppm, nxt_stb;
    logic        srq_ff, ist_ff, req_rise;
    ssr_rsp_t    rsp_ff;
    logic [15:0] o_cnd, o_ris, o_fal, o_evt, o_ena;
    logic [15:0] q_cnd, q_ris, q_fal, q_evt, q_ena;
    logic        oper_sum, ques_sum, wr, rd;
    logic [7:0]  wbyte;

    assign wr    = i_cmd.wr;
    assign rd    = i_cmd.rd;
    assign wbyte = i_cmd.wdata[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // operation and questionable registers
    ssr_status_reg #(.W(STAT_W)) u_oper (
        .i_mclk   (i_mclk),
        .i_rst_b  (i_rst_b),
        .i_cond   (i_oper_cond),
        .i_wr_ris (wr && i_cmd.sel == SEL_O_RIS),
        .i_wr_fal (wr && i_cmd.sel == SEL_O_FAL),
        .i_wr_ena (wr && i_cmd.sel == SEL_O_ENA),
        .i_wdata  (i_cmd.wdata),
        .i_rd_evt (rd && i_cmd.sel == SEL_O_EVT),
        .o_cond   (o_cnd),
        .o_ris    (o_ris),
        .o_fal    (o_fal),
        .o_evt    (o_evt),
        .o_ena    (o_ena),
        .o_sum    (oper_sum)
    );

    ssr_status_reg #(.W(STAT_W)) u_ques (
        .i_mclk   (i_mclk),
        .i_rst_b  (i_rst_b),
        .i_cond   (i_ques_cond),
        .i_wr_ris (wr && i_cmd.sel == SEL_Q_RIS),
        .i_wr_fal (wr && i_cmd.sel == SEL_Q_FAL),
        .i_wr_ena (wr && i_cmd.sel == SEL_Q_ENA),
        .i_wdata  (i_cmd.wdata),
        .i_rd_evt (rd && i_cmd.sel == SEL_Q_EVT),
        .o_cond   (q_cnd),
        .o_ris    (q_ris),
        .o_fal    (q_fal),
        .o_evt    (q_evt),
        .o_ena    (q_ena),
        .o_sum    (ques_sum)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next values of byte-wide parts
    always_comb begin
        nxt_esl = (rd && i_cmd.sel == SEL_ESL) ? RST_BYTE : esl_ff;
        nxt_esl = nxt_esl | (i_esl_set & ESL_USED);
        nxt_esm = (wr && i_cmd.sel == SEL_ESM) ? wbyte : esm_ff;
        nxt_sre = (wr && i_cmd.sel == SEL_SRE) ? (wbyte & NOT_MSS) : sre_ff;
        nxt_ppm = (wr && i_cmd.sel == SEL_PPM) ? wbyte : ppm_ff;
        nxt_stb = RST_BYTE;
        nxt_stb[STB_ERRQ] = i_errq_nonempty;
        nxt_stb[STB_QUES] = ques_sum;
        nxt_stb[STB_MAV]  = i_msg_waiting;
        nxt_stb[STB_ESB]  = |(nxt_esl & nxt_esm);
        nxt_stb[STB_OPER] = oper_sum;
        nxt_stb[STB_MSS]  = |(nxt_stb & nxt_sre & NOT_MSS);
    end

    // a masked status bit going high asks for service
    assign req_rise = |(nxt_stb & ~stb_ff & nxt_sre & NOT_MSS);

    // byte-wide registers
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            esl_ff <= RST_BYTE;
            esm_ff <= RST_BYTE;
            sre_ff <= RST_BYTE;
            ppm_ff <= RST_BYTE;
            stb_ff <= RST_BYTE;
        end else begin
            esl_ff <= nxt_esl;
            esm_ff <= nxt_esm;
            sre_ff <= nxt_sre;
            ppm_ff <= nxt_ppm;
            stb_ff <= nxt_stb;
        end
    end

    // service request: set wins over poll or summary drop
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b)                              srq_ff <= 1'b0;
        else if (req_rise)                         srq_ff <= 1'b1;
        else if (i_serial_poll || !nxt_stb[STB_MSS]) srq_ff <= 1'b0;
    end

    // individual flag, bit 6 counted here
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) ist_ff <= 1'b0;
        else          ist_ff <= |(nxt_stb & nxt_ppm);
    end

    ////////////////////////////////////////////////////////////////////////////
    // read answer, one cycle after the request
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.valid <= rd | i_serial_poll;
            rsp_ff.data  <= RST_WORD;
            if (i_serial_poll) begin
                rsp_ff.data[7:0] <= stb_ff;
            end else if (rd) begin
                unique case (i_cmd.sel)
                    SEL_STB:   rsp_ff.data[7:0] <= stb_ff;
                    SEL_SRE:   rsp_ff.data[7:0] <= sre_ff;
                    SEL_ESL:   rsp_ff.data[7:0] <= esl_ff;
                    SEL_ESM:   rsp_ff.data[7:0] <= esm_ff;
                    SEL_PPM:   rsp_ff.data[7:0] <= ppm_ff;
                    SEL_IST:   rsp_ff.data[0]   <= ist_ff;
                    SEL_O_CND: rsp_ff.data <= o_cnd;
                    SEL_O_RIS: rsp_ff.data <= o_ris;
                    SEL_O_FAL: rsp_ff.data <= o_fal;
                    SEL_O_EVT: rsp_ff.data <= o_evt;
                    SEL_O_ENA: rsp_ff.data <= o_ena;
                    SEL_Q_CND: rsp_ff.data <= q_cnd;
                    SEL_Q_RIS: rsp_ff.data <= q_ris;
                    SEL_Q_FAL: rsp_ff.data <= q_fal;
                    SEL_Q_EVT: rsp_ff.data <= q_evt;
                    SEL_Q_ENA: rsp_ff.data <= q_ena;
                    default:   rsp_ff.data <= RST_WORD;  // unmapped select
                endcase
            end
        end
    end

    assign o_rsp = rsp_ff;
    assign o_stb = stb_ff;
    assign o_srq = srq_ff;
    assign o_ist = ist_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_mss;
        @(posedge i_mclk) disable iff (!i_rst_b)
        stb_ff[STB_MSS] == |(stb_ff & sre_ff & NOT_MSS);
    endproperty
    a_mss: assert property (p_mss) else $error("bad bit 6");

    property p_sre6;
        @(posedge i_mclk) disable iff (!i_rst_b)
        !sre_ff[STB_MSS];
    endproperty
    a_sre6: assert property (p_sre6) else $error("mask bit 6 set");

    property p_srq_rise;
        @(posedge i_mclk) disable iff (!i_rst_b)
        req_rise |=> srq_ff;
    endproperty
    a_srq_rise: assert property (p_srq_rise) else $error("no request");

    property p_srq_cause;
        @(posedge i_mclk) disable iff (!i_rst_b)
        $rose(srq_ff) |-> $past(req_rise);
    endproperty
    a_srq_cause: assert property (p_srq_cause) else $error("stray request");

    property p_esb;
        @(posedge i_mclk) disable iff (!i_rst_b)
        stb_ff[STB_ESB] == |(esl_ff & esm_ff);
    endproperty
    a_esb: assert property (p_esb) else $error("bad bit 5");

    property p_ist;
        @(posedge i_mclk) disable iff (!i_rst_b)
        ist_ff == |(stb_ff & ppm_ff);
    endproperty
    a_ist: assert property (p_ist) else $error("bad flag");

    property p_tree;
        @(posedge i_mclk) disable iff (!i_rst_b)
        ##1 (stb_ff[STB_OPER] == $past(oper_sum)) && (stb_ff[STB_QUES] == $past(ques_sum));
    endproperty
    a_tree: assert property (p_tree) else $error("summary lost");

    property p_pins;
        @(posedge i_mclk) disable iff (!i_rst_b)
        ##1 (stb_ff[STB_ERRQ] == $past(i_errq_nonempty)) && (stb_ff[STB_MAV] == $past(i_msg_waiting));
    endproperty
    a_pins: assert property (p_pins) else $error("bad bit 2 or 4");

    property p_unused;
        @(posedge i_mclk) disable iff (!i_rst_b)
        !esl_ff[ESL_UNU] && (stb_ff[1:0] == 2'h0);
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit set");

    property p_poll;
        @(posedge i_mclk) disable iff (!i_rst_b)
        i_serial_poll |=> (rsp_ff.valid && rsp_ff.data[7:0] == $past(stb_ff));
    endproperty
    a_poll: assert property (p_poll) else $error("poll answer");

    c_srq: cover property (@(posedge i_mclk) disable iff (!i_rst_b) $rose(srq_ff));
    c_ist: cover property (@(posedge i_mclk) disable iff (!i_rst_b) $rose(ist_ff));
    c_rc_evt: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        rd && i_cmd.sel == SEL_ESL && i_esl_set != RST_BYTE);
    c_poll_clr: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        srq_ff && i_serial_poll ##1 !srq_ff);

endmodule : ssr_status_reporting

`default_nettype wire
